// ### pkg/ldm_pkg.sv
// Constants, types and register map for the load-multiple execute block
package ldm_pkg;

  // =====================================================
  // Register map (byte addresses)
  // =====================================================
  localparam logic [7:0] CTRL_OFS     = 8'h00; // Control: go, cond, acceptance, it bits
  localparam logic [7:0] INSTR_OFS    = 8'h04; // Instruction word
  localparam logic [7:0] BASE_OFS     = 8'h08; // Base register value
  localparam logic [7:0] PCVAL_OFS    = 8'h0c; // Program counter value
  localparam logic [7:0] STATUS_OFS   = 8'h10; // Sticky events, write one to clear
  localparam logic [7:0] MASK_OFS     = 8'h14; // Interrupt mask
  localparam logic [7:0] STATE_OFS    = 8'h18; // Busy, writeback flag, count
  localparam logic [7:0] WBVAL_OFS    = 8'h1c; // Writeback value
  localparam logic [7:0] TARGET_OFS   = 8'h20; // Branch target
  localparam logic [7:0] REGDATA_OFS  = 8'h40; // 16 words of loaded registers

  // =====================================================
  // Field positions
  // =====================================================
  localparam int CTRL_GO       = 0;  // Write one to start
  localparam int CTRL_COND     = 1;  // Condition passed
  localparam int CTRL_ACCEPT   = 2;  // Coprocessor accepts
  localparam int CTRL_IN_IT    = 3;  // Inside if-then block
  localparam int CTRL_LAST_IT  = 4;  // Last in if-then block

  // Status bits
  localparam int EV_DONE   = 0;
  localparam int EV_UNDEF  = 1;
  localparam int EV_USAGE  = 2;
  localparam int EV_COPROC = 3;
  localparam int EV_MEMF   = 4;
  localparam int EV_BRANCH = 5;
  localparam int EV_POP    = 6;
  localparam int EV_W      = 7;

  localparam logic [31:0] ZERO32   = 32'h0;
  localparam logic [31:0] WORD_INC = 32'h4;
  localparam logic [3:0]  SP_NUM   = 4'hd;
  localparam logic [3:0]  PC_NUM   = 4'hf;

  // Opcode patterns
  localparam logic [4:0] SHORT_OP = 5'h19;  // 11001
  localparam logic [9:0] WIDE_OP  = 10'h3a2; // 1110100010

  // Memory read request
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } mem_req_t;

  // Memory answer
  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [31:0] data;
  } mem_rsp_t;

  // Word to coprocessor
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } cop_word_t;

  typedef enum logic [1:0] { MEM_OKAY_RESP = 2'h0, MEM_SLVERR_RESP = 2'h2 } axi_resp_t;

endpackage

// ### design/load_multiple_decode.sv
// Load-multiple and coprocessor literal load executor with AXI4-Lite registers
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
module load_multiple_decode (
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // AXI4-Lite write address
  input  wire logic              AWVALID,
  output      logic              AWREADY,
  input  wire logic [7:0]        AWADDR,
  // AXI4-Lite write data
  input  wire logic              WVALID,
  output      logic              WREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  // AXI4-Lite write response
  output      logic              BVALID,
  input  wire logic              BREADY,
  output      logic [1:0]        BRESP,
  // AXI4-Lite read
  input  wire logic              ARVALID,
  output      logic              ARREADY,
  input  wire logic [7:0]        ARADDR,
  output      logic              RVALID,
  input  wire logic              RREADY,
  output      logic [31:0]       RDATA,
  output      logic [1:0]        RRESP,
  // Memory port
  output      ldm_pkg::mem_req_t MEM_REQ,
  input  wire ldm_pkg::mem_rsp_t MEM_RSP,
  // Coprocessor port
  output      ldm_pkg::cop_word_t COP_WORD,
  input  wire logic              COP_DONE,
  // Interrupt
  output      logic              IRQ
);
  import ldm_pkg::*;

  typedef enum { IDLE, DECODE, LDM_RD, COP_RD, FINISH } state_t;

  // =====================================================
  // Storage
  // =====================================================
  state_t       state;                 // Sequencer state
  logic [4:0]   ctrl;                  // Control bits
  logic [31:0]  instr;                 // Instruction under execution
  logic [31:0]  base_val;              // Base register input
  logic [31:0]  pc_val;                // Program counter input
  logic [7:0]   status;                // Sticky events
  logic [7:0]   mask;                  // Interrupt mask
  logic [31:0]  regs [16];             // Loaded register words
  logic [15:0]  pending;               // Registers still to load
  logic [31:0]  addr;                  // Current memory address
  logic [31:0]  wb_val;                // Writeback value
  logic         wb_en;                 // Writeback applies
  logic [31:0]  target;                // Branch target
  logic [4:0]   count;                 // Words transferred
  logic [7:0]   ev;                    // Events this cycle
  logic         go;                    // Start pulse
  logic         aw_held, w_held;       // Write halves taken
  logic [7:0]   aw_addr;               // Latched write address
  logic [31:0]  w_data;                // Latched write data

  // Count set bits; used for the list checks and writeback
  function automatic logic [4:0] popcount(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h0;
    for (int i = 0; i < 16; i++) n = n + {4'h0, v[i]};
    return n;
  endfunction

  // Index of lowest set bit
  function automatic logic [3:0] lowest(input logic [15:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 15; i >= 0; i--) if (v[i]) n = i[3:0];
    return n;
  endfunction

  // =====================================================
  // Decode (combinational)
  // =====================================================
  logic        is_short, is_wide, is_cop;
  logic [15:0] list;
  logic [3:0]  base_num;
  logic        wb_req, undef, pop;
  logic [31:0] pc_al, off_imm, offset_addr;

  always_comb begin
    // Short form sits alone in the low half; upper half must be clear
    is_short = instr[31:16] == 16'h0 && instr[15:11] == SHORT_OP;
    is_wide  = instr[31:22] == WIDE_OP && instr[20];
    is_cop   = !is_short && !is_wide;
    base_num = is_short ? {1'b0, instr[10:8]} : instr[19:16];
    // Short mask zero-extended; wide mask PC:LR:0:list
    list     = is_short ? {8'h00, instr[7:0]}
                        : {instr[15], instr[14], 1'b0, instr[12:0]};
    wb_req   = is_short ? !list[base_num] : instr[21];
    pop      = is_wide && instr[21] && base_num == SP_NUM;
    undef    = 1'b0;
    if (is_short && popcount(list) < 5'd1) undef = 1'b1;
    if (is_wide && (base_num == PC_NUM || popcount(list) < 5'd2
        || (instr[15] && instr[14]))) undef = 1'b1;
    if (is_wide && list[15] && ctrl[CTRL_IN_IT] && !ctrl[CTRL_LAST_IT]) undef = 1'b1;
    if (is_wide && instr[21] && list[base_num]) undef = 1'b1;
    // Coprocessor literal: U bit 23, P bit 24, imm8 scaled by four
    pc_al       = {pc_val[31:2], 2'b00};
    off_imm     = {22'h0, instr[7:0], 2'b00};
    offset_addr = instr[23] ? pc_al + off_imm : pc_al - off_imm;
  end

  // =====================================================
  // AXI4-Lite write side
  // =====================================================
  // Either half may arrive first; the response waits for both
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      AWREADY <= 1'b0; WREADY <= 1'b0; BVALID <= 1'b0; BRESP <= MEM_OKAY_RESP;
      aw_held <= 1'b0; w_held <= 1'b0; aw_addr <= 8'h0; w_data <= ZERO32;
    end else begin
      AWREADY <= !aw_held && !AWREADY && !BVALID;
      WREADY  <= !w_held && !WREADY && !BVALID;
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1; aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1; w_data <= WDATA;
      end
      if (aw_held && w_held && !BVALID) begin
        BVALID <= 1'b1;
        BRESP  <= (aw_addr > TARGET_OFS && aw_addr < REGDATA_OFS) ? MEM_SLVERR_RESP : MEM_OKAY_RESP;
        aw_held <= 1'b0; w_held <= 1'b0;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  wire wr_fire = aw_held && w_held && !BVALID && WSTRB != 4'h0;

  // Software-written control registers; go is a pulse, refused while busy
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl <= 5'h0; instr <= ZERO32; base_val <= ZERO32; pc_val <= ZERO32;
      mask <= 8'h0; go <= 1'b0;
    end else begin
      go <= 1'b0;
      if (wr_fire && state == IDLE) begin
        unique case (aw_addr)
          CTRL_OFS:  begin ctrl <= w_data[4:0]; go <= w_data[CTRL_GO]; end
          INSTR_OFS: instr    <= w_data;
          BASE_OFS:  base_val <= w_data;
          PCVAL_OFS: pc_val   <= w_data;
          MASK_OFS:  mask     <= w_data[7:0];
          default:   ;
        endcase
      end else if (wr_fire && aw_addr == MASK_OFS) begin
        mask <= w_data[7:0];
      end
    end
  end

  // Sticky status: a new event wins over a clearing write
  always_ff @(posedge CLOCK) begin
    if (RST) status <= 8'h0;
    else if (wr_fire && aw_addr == STATUS_OFS) status <= (status & ~w_data[7:0]) | ev;
    else status <= status | ev;
  end

  // Level interrupt from unmasked status
  always_ff @(posedge CLOCK) begin
    if (RST) IRQ <= 1'b0;
    else IRQ <= |(status & mask);
  end

  // =====================================================
  // AXI4-Lite read side
  // =====================================================
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ARREADY <= 1'b0; RVALID <= 1'b0; RDATA <= ZERO32; RRESP <= MEM_OKAY_RESP;
    end else begin
      ARREADY <= !ARREADY && !RVALID;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP  <= MEM_OKAY_RESP;
        if (ARADDR >= REGDATA_OFS) RDATA <= regs[ARADDR[5:2]];
        else begin
          unique case (ARADDR)
            CTRL_OFS:   RDATA <= {27'h0, ctrl};
            INSTR_OFS:  RDATA <= instr;
            BASE_OFS:   RDATA <= base_val;
            PCVAL_OFS:  RDATA <= pc_val;
            STATUS_OFS: RDATA <= {24'h0, status};
            MASK_OFS:   RDATA <= {24'h0, mask};
            STATE_OFS:  RDATA <= {25'h0, count, wb_en, state != IDLE};
            WBVAL_OFS:  RDATA <= wb_val;
            TARGET_OFS: RDATA <= target;
            default: begin RDATA <= ZERO32; RRESP <= MEM_SLVERR_RESP; end
          endcase
        end
      end else if (RVALID && RREADY) RVALID <= 1'b0;
    end
  end

  // =====================================================
  // Sequencer
  // =====================================================
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state <= IDLE; pending <= 16'h0; addr <= ZERO32; wb_val <= ZERO32; wb_en <= 1'b0;
      target <= ZERO32; count <= 5'h0; ev <= 8'h0; MEM_REQ <= '0; COP_WORD <= '0;
      for (int i = 0; i < 16; i++) regs[i] <= ZERO32;
    end else begin
      ev <= 8'h0;
      COP_WORD.valid <= 1'b0;
      unique case (state)
        IDLE: if (go) begin
          state <= DECODE; count <= 5'h0; wb_en <= 1'b0;
        end
        DECODE: begin
          if (!ctrl[CTRL_COND]) begin
            ev[EV_DONE] <= 1'b1; state <= IDLE;
          end else if (is_cop) begin
            if (!ctrl[CTRL_ACCEPT]) begin
              ev[EV_COPROC] <= 1'b1; state <= IDLE;
            end else begin
              addr  <= instr[24] ? offset_addr : pc_al;
              MEM_REQ.valid <= 1'b1;
              MEM_REQ.addr  <= instr[24] ? offset_addr : pc_al;
              state <= COP_RD;
            end
          end else if (undef) begin
            ev[EV_UNDEF] <= 1'b1; state <= IDLE;
          end else begin
            ev[EV_POP] <= pop;
            pending <= list;
            addr    <= base_val;
            wb_en   <= wb_req;
            wb_val  <= base_val + {popcount(list), 2'b00};
            MEM_REQ.valid <= 1'b1;
            MEM_REQ.addr  <= base_val;
            state <= LDM_RD;
          end
        end
        LDM_RD: if (MEM_RSP.valid) begin
          MEM_REQ.valid <= 1'b0;
          if (MEM_RSP.fault) begin
            ev[EV_MEMF] <= 1'b1; state <= IDLE;
          end else begin
            regs[lowest(pending)] <= MEM_RSP.data;
            if (lowest(pending) == PC_NUM) begin
              target <= {MEM_RSP.data[31:1], 1'b0};
              if (!MEM_RSP.data[0]) ev[EV_USAGE] <= 1'b1;
              else ev[EV_BRANCH] <= 1'b1;
            end
            pending[lowest(pending)] <= 1'b0;
            count <= count + 5'd1;
            addr  <= addr + WORD_INC;
            if (popcount(pending) == 5'd1) state <= FINISH;
            else begin
              MEM_REQ.valid <= 1'b1; MEM_REQ.addr <= addr + WORD_INC;
            end
          end
        end
        COP_RD: if (MEM_RSP.valid) begin
          MEM_REQ.valid <= 1'b0;
          if (MEM_RSP.fault) begin
            ev[EV_MEMF] <= 1'b1; state <= IDLE;
          end else begin
            COP_WORD.valid <= 1'b1; COP_WORD.data <= MEM_RSP.data;
            count <= count + 5'd1;
            addr  <= addr + WORD_INC;
            if (COP_DONE) state <= FINISH;
            else begin
              MEM_REQ.valid <= 1'b1; MEM_REQ.addr <= addr + WORD_INC;
            end
          end
        end
        FINISH: begin
          ev[EV_DONE] <= 1'b1; ev[EV_W] <= wb_en; state <= IDLE;
        end
      endcase
    end
  end

  // =====================================================
  // Checks
  // =====================================================
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence cop_reject_s; state == DECODE && ctrl[CTRL_COND] && is_cop && !ctrl[CTRL_ACCEPT]; endsequence
  cop_reject_a: assert property (cop_reject_s |=> state == IDLE && !MEM_REQ.valid ##1 status[EV_COPROC])
    else $error("rejected coprocessor load touched memory");
  cop_addr_a: assert property (state == DECODE && ctrl[CTRL_COND] && is_cop && ctrl[CTRL_ACCEPT]
    |=> MEM_REQ.addr[1:0] == 2'b00)
    else $error("literal address not word aligned");
  addr_step_a: assert property (state inside {LDM_RD, COP_RD} && MEM_RSP.valid && !MEM_RSP.fault
    && MEM_REQ.valid |=> addr == $past(addr) + WORD_INC)
    else $error("address did not advance by four");
  wb_value_a: assert property (state == FINISH |-> wb_val == base_val + {count, 2'b00} || is_cop)
    else $error("writeback value wrong");
  pc_fault_a: assert property (state == LDM_RD && MEM_RSP.valid && !MEM_RSP.fault
    && lowest(pending) == PC_NUM && !MEM_RSP.data[0] |=> ##1 status[EV_USAGE])
    else $error("clear bit zero did not fault");
  sp_never_a: assert property (state == LDM_RD |-> !pending[SP_NUM])
    else $error("stack pointer scheduled for load");
  short_empty_a: assert property (state == DECODE && ctrl[CTRL_COND] && is_short
    && instr[7:0] == 8'h00 |=> ##1 status[EV_UNDEF])
    else $error("empty short list accepted");
  cond_nop_a: assert property (state == DECODE && !ctrl[CTRL_COND] |=> state == IDLE && !MEM_REQ.valid)
    else $error("failed condition still executed");
  wide_pair_a: assert property (state == DECODE && is_wide && instr[15] && instr[14] && ctrl[CTRL_COND]
    |=> state == IDLE)
    else $error("PC with link register accepted");
endmodule

// ### tb/mem_cop_model.sv
// Memory and coprocessor partner model for the load-multiple block
module mem_cop_model (
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // Design side
  input  wire ldm_pkg::mem_req_t  MEM_REQ,
  output      ldm_pkg::mem_rsp_t  MEM_RSP,
  input  wire ldm_pkg::cop_word_t COP_WORD,
  output      logic              COP_DONE,
  // Bench controls
  input  wire logic              CLR,
  input  wire logic              SLOW,
  input  wire logic [31:0]       FAULT_ADDR,
  input  wire logic [31:0]       EVEN_ADDR,
  input  wire logic [4:0]        DONE_WORDS
);
  timeunit 1ns;
  timeprecision 1ps;
  import ldm_pkg::*;
  logic [1:0]  wait_cnt;   // Answer delay left
  logic        busy;       // Request taken, answer pending
  logic        cool;       // Idle edge after an answer
  logic [31:0] addr;       // Address in service
  int          served;     // Answers since clear
  int          words;      // Coprocessor words since clear
  logic [31:0] first_addr; // First address since clear
  logic [31:0] last_addr;  // Latest address taken
  // ========================================
  // Memory: word is ~address, so bit0 set, except at EVEN_ADDR where bit0 is cleared
  // ========================================
  always_ff @(posedge CLOCK) begin
    if (RST || CLR) begin
      busy    <= 1'b0;
      cool    <= 1'b0;
      served  <= 0;
      words   <= 0;
      MEM_RSP <= '0;
    end else begin
      MEM_RSP.valid <= 1'b0;
      // Released data keeps moving, never a stale match
      MEM_RSP.data  <= ~MEM_RSP.data;
      cool          <= 1'b0;
      if (COP_WORD.valid)
        words <= words + 1;
      // Cool edge: request still up while design sees answer
      if (MEM_REQ.valid && !busy && !cool) begin
        busy      <= 1'b1;
        addr      <= MEM_REQ.addr;
        last_addr <= MEM_REQ.addr;
        wait_cnt  <= SLOW ? 2'h3 : 2'h0;
        if (served == 0)
          first_addr <= MEM_REQ.addr;
      end else if (busy && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (busy) begin
        busy          <= 1'b0;
        cool          <= 1'b1;
        served        <= served + 1;
        MEM_RSP.valid <= 1'b1;
        MEM_RSP.fault <= (addr == FAULT_ADDR);
        MEM_RSP.data  <= (addr == EVEN_ADDR) ? ~addr ^ 32'h1 : ~addr;
      end
    end
  end
  // Coprocessor done after the set word count
  assign COP_DONE = (served >= int'(DONE_WORDS));
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the load-multiple block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ldm_pkg::*;
  logic        clock, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, cop_done, irq, clr, slow;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, fault_addr, even_addr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [4:0]  done_words;
  mem_req_t    mem_req;
  mem_rsp_t    mem_rsp;
  cop_word_t   cop_word;
  int          error_cnt, tests_run, cycles;
  load_multiple_decode dut (.CLOCK(clock), .RST(rst),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready),
    .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
    .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready),
    .RDATA(rdata), .RRESP(rresp), .MEM_REQ(mem_req), .MEM_RSP(mem_rsp),
    .COP_WORD(cop_word), .COP_DONE(cop_done), .IRQ(irq));
  mem_cop_model partner (.CLOCK(clock), .RST(rst), .MEM_REQ(mem_req), .MEM_RSP(mem_rsp),
    .COP_WORD(cop_word), .COP_DONE(cop_done), .CLR(clr), .SLOW(slow),
    .FAULT_ADDR(fault_addr), .EVEN_ADDR(even_addr), .DONE_WORDS(done_words));
  // ========================================
  // Clock and hang guard
  // ========================================
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ========================================
  // Shared tasks
  // ========================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clock);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Clear events, load operands, start, wait for idle, fetch events
  task automatic run(input logic [31:0] ins, base, pc, input logic [4:0] ctl, output logic [31:0] st);
    logic [1:0] r;
    int n;
    clr <= 1'b1;
    wr(STATUS_OFS, 32'hff, r);
    clr <= 1'b0;
    wr(INSTR_OFS, ins, r);
    wr(BASE_OFS, base, r);
    wr(PCVAL_OFS, pc, r);
    wr(CTRL_OFS, {27'h0, ctl}, r);
    n = 0;
    do begin
      rd(STATE_OFS, st, r);
      n++;
    end while (st[0] !== 1'b0 && n < 100);
    rd(STATUS_OFS, st, r);
  endtask
  function automatic logic [31:0] wide(input logic w, input logic [3:0] rn, input logic [15:0] lo);
    return {WIDE_OP, w, 1'b1, rn, lo};
  endfunction
  // ========================================
  // Scenarios
  // ========================================
  task automatic t_short();
    logic [31:0] st, d;
    logic [1:0] r;
    run({16'h0, SHORT_OP, 3'h2, 8'h0b}, 32'h2000, 32'h0, 5'h07, st);
    check(st[EV_W], 32'h1);
    rd(WBVAL_OFS, d, r);
    check(d, 32'h200c);
    rd(REGDATA_OFS, d, r);
    check(d, ~32'h2000);
    rd(REGDATA_OFS + 8'hc, d, r);
    check(d, ~32'h2008);
    run({16'h0, SHORT_OP, 3'h1, 8'h03}, 32'h2000, 32'h0, 5'h07, st);
    check(st[EV_W], 32'h0);
    run({16'h0, SHORT_OP, 3'h2, 8'h00}, 32'h2000, 32'h0, 5'h07, st);
    check(st[EV_UNDEF], 32'h1);
  endtask
  task automatic t_wide();
    logic [31:0] st, d;
    logic [1:0] r;
    slow <= 1'b1;
    run(wide(1'b1, 4'h1, 16'h8001), 32'h3000, 32'h0, 5'h07, st);
    check(st[EV_BRANCH], 32'h1);
    rd(TARGET_OFS, d, r);
    check(d, ~32'h3005);
    rd(WBVAL_OFS, d, r);
    check(d, 32'h3008);
    even_addr <= 32'h3004;
    run(wide(1'b1, 4'h1, 16'h8001), 32'h3000, 32'h0, 5'h07, st);
    check(st[EV_USAGE], 32'h1);
    even_addr <= '1;
    slow <= 1'b0;
    run(wide(1'b1, SP_NUM, 16'h2003), 32'h4000, 32'h0, 5'h07, st);
    check(st[EV_POP], 32'h1);
    check(partner.served, 32'h2);
  endtask
  task automatic t_undef();
    logic [31:0] st;
    logic [31:0] ins [5];
    ins[0] = wide(1'b0, PC_NUM, 16'h0003);
    ins[1] = wide(1'b0, 4'h1, 16'h0001);
    ins[2] = wide(1'b0, 4'h1, 16'hc001);
    ins[3] = wide(1'b1, 4'h1, 16'h0003);
    ins[4] = wide(1'b0, 4'h1, 16'h8001);
    for (int i = 0; i < 5; i++) begin
      run(ins[i], 32'h5000, 32'h0, (i == 4) ? 5'h0f : 5'h07, st);
      check(st[EV_UNDEF], 32'h1);
    end
  endtask
  task automatic t_lit();
    logic [31:0] st;
    logic [31:0] ins [3];
    logic [31:0] exp [3];
    ins[0] = 32'hed9f5e03;
    ins[1] = 32'hed1f5e03;
    ins[2] = 32'hec9f5e03;
    exp[0] = 32'h100c;
    exp[1] = 32'h0ff4;
    exp[2] = 32'h1000;
    done_words <= 5'h3;
    for (int i = 0; i < 3; i++) begin
      slow <= i[0];
      run(ins[i], 32'h0, 32'h1002, 5'h07, st);
      check(partner.first_addr, exp[i]);
      check(partner.last_addr, exp[i] + 32'h8);
      check(partner.words, 32'h3);
    end
    run(ins[0], 32'h0, 32'h1002, 5'h03, st);
    check(st[EV_COPROC], 32'h1);
    check(partner.served, 32'h0);
    fault_addr <= 32'h1010;
    run(ins[0], 32'h0, 32'h1002, 5'h07, st);
    check(st[EV_MEMF], 32'h1);
    fault_addr <= '1;
    run(ins[0], 32'h0, 32'h1002, 5'h05, st);
    check(partner.served, 32'h0);
  endtask
  // Interrupt masking and clearing, unmapped offsets
  task automatic t_misc();
    logic [31:0] st, d;
    logic [1:0] r;
    wr(MASK_OFS, 32'h0, r);
    run({16'h0, SHORT_OP, 3'h2, 8'h01}, 32'h2000, 32'h0, 5'h07, st);
    check(irq, 32'h0);
    wr(MASK_OFS, 32'h1, r);
    repeat (2) @(posedge clock);
    check(irq, 32'h1);
    wr(STATUS_OFS, 32'h1, r);
    repeat (2) @(posedge clock);
    check(irq, 32'h0);
    rd(8'h24, d, r);
    check(r, MEM_SLVERR_RESP);
    check(d, 32'h0);
    wr(8'h28, 32'h1, r);
    check(r, MEM_SLVERR_RESP);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ========================================
  // Main sequence
  // ========================================
  initial begin
    clock = 1'b0; rst = 1'b1; clr = 1'b0; slow = 1'b0; cycles = 0; error_cnt = 0; tests_run = 0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; wstrb = 4'h0;
    fault_addr = '1; even_addr = '1; done_words = 5'h1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_short();
    t_wide();
    t_undef();
    t_lit();
    t_misc();
    stop_test();
  end
endmodule
